//--- design/reqal_pkg.sv
/*
 Package for the rail enable qualifier: register indices, field positions,
 reset values, timing constants, carrier structs and the delay code table.
 Assumes a 200 MHz register clock.
*/
package reqal_pkg;
   // Clock and time base
   localparam int CLK_PERIOD_NS = 5;
   localparam int MS_NS = 1_000_000;
   localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_MASK_A = 8'h1F;
   localparam logic [7:0] IDX_MASK_B = 8'h20;
   localparam logic [7:0] IDX_DELAY = 8'h21;
   localparam logic [7:0] IDX_STATUS = 8'h30;

   // Reset values
   localparam logic [7:0] RST_MASK_A = 8'h00;
   localparam logic [7:0] RST_MASK_B = 8'h00;
   localparam logic [7:0] RST_DELAY = 8'h00;

   // Second byte fields
   localparam int MASKB_SECOND_BANK_BIT = 0;
   localparam int MASKB_SHARED_BIT = 1;
   localparam int PINSEL_LSB = 2;
   localparam int PINSEL_W = 3;
   localparam int VOPT_BIT = 7;

   // Delay register fields
   localparam int RISE_LSB = 0;
   localparam int FALL_LSB = 3;
   localparam int DLY_W = 3;

   // Enable source codes
   localparam logic [2:0] SEL_IN_ONE = 3'h0;
   localparam logic [2:0] SEL_IN_TWO = 3'h1;
   localparam logic [2:0] SEL_IN_FIVE = 3'h2;
   localparam logic [2:0] SEL_IN_FOUR = 3'h3;
   localparam logic [2:0] SEL_IN_THREE = 3'h4;
   localparam logic [2:0] SEL_IN_PAIR = 3'h5;
   localparam logic [2:0] SEL_IN_SIX = 3'h6;
   localparam logic [2:0] SEL_ONE = 3'h7;

   // Good flags of the other rails, packed in first-byte mask order at the bottom
   typedef struct packed {
      logic shared_switch_regulator_rail;
      logic second_bank_first_switch;
      logic second_small_linear_regulator;
      logic first_load_switch;
      logic [5:0] step_down_rail;
   } reqal_good_t;

   typedef struct packed {
      logic control_input_six;
      logic control_input_five;
      logic control_input_four;
      logic control_input_three;
      logic control_input_two;
      logic control_input_one;
   } reqal_ctl_t;

   // Delay code to milliseconds
   function automatic logic [6:0] reqal_delay_ms(input logic [2:0] code);
      logic [6:0] ms;
      ms = 7'h00;
      unique case (code)
         3'h0: ms = 7'h00;
         3'h1: ms = 7'h02;
         3'h2: ms = 7'h04;
         3'h3: ms = 7'h08;
         3'h4: ms = 7'h10;
         3'h5: ms = 7'h18;
         3'h6: ms = 7'h20;
         3'h7: ms = 7'h40;
      endcase
      return ms;
   endfunction : reqal_delay_ms
endpackage : reqal_pkg

//--- design/reqal_edge_delay.sv
/*
 Edge delay for the qualified rail enable: the output follows the request
 after the rising or falling delay chosen by a 3-bit code.
 Assumes codes are stable while a wait runs; a change applies at the next edge.
*/
`timescale 1ns/1ps
module reqal_edge_delay #(
   parameter int MS_CYCLES = reqal_pkg::MS_CYCLES
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Request and delay codes
   input wire logic request,
   input wire logic [2:0] rise_code,
   input wire logic [2:0] fall_code,
   // Delayed level and wait flag
   output logic level,
   output logic busy
);
   import reqal_pkg::*;

   // The longest wait, 64 ms, must fit the 32-bit counter
   if (MS_CYCLES < 1 || MS_CYCLES > 32'h03FF_FFFF) begin : g_bad_ms
      $error("reqal_edge_delay: MS_CYCLES must be from 1 to 67108863");
   end

   typedef enum logic {REQAL_IDLE, REQAL_WAIT} reqal_dly_state_t;

   reqal_dly_state_t state;
   reqal_dly_state_t next_state;
   logic [31:0] cnt;
   logic [31:0] next_cnt;
   logic next_level;
   logic [6:0] wait_ms;

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_level = level;
      wait_ms = reqal_delay_ms(request ? rise_code : fall_code);
      unique case (state)
         REQAL_IDLE: begin
            if (request != level) begin
               if (wait_ms == 7'h00) begin
                  next_level = request;
               end else begin
                  next_state = REQAL_WAIT;
                  next_cnt = 32'(32'(wait_ms) * MS_CYCLES - 1);
               end
            end
         end
         REQAL_WAIT: begin
            if (request == level) begin
               next_state = REQAL_IDLE;
            end else if (cnt == 32'h0) begin
               next_level = request;
               next_state = REQAL_IDLE;
            end else begin
               next_cnt = cnt - 32'h1;
            end
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state <= REQAL_IDLE;
         cnt <= 32'h0;
         level <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         level <= next_level;
      end
   end

   assign busy = (state == REQAL_WAIT);

   a_zero_delay: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == REQAL_IDLE && request != level && wait_ms == 7'h00) |=> level == $past(request))
      else $error("Zero delay did not pass the edge in one cycle");
   a_hold_wait: assert property (@(posedge hclk) disable iff (!hresetn)
      (state == REQAL_WAIT && cnt != 32'h0) |=> $stable(level))
      else $error("Level changed before the delay ran out");
endmodule : reqal_edge_delay

//--- design/reqal_top.sv
/*
 Rail enable qualifier for one small linear regulator: AHB-Lite register
 slave, enable source select, good-flag masking, edge delays and the pin
 voltage override of step-down rail six.
 Assumes control pins, sleep pin and good flags are synchronous to hclk.
*/
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ps
module reqal_top #(
   parameter int MS_CYCLES = reqal_pkg::MS_CYCLES
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Control pins and rail status
   input wire reqal_pkg::reqal_ctl_t ctl,
   input wire logic second_control_pin,
   input wire logic sleep_pin,
   input wire logic rail_six_coarse_step,
   input wire reqal_pkg::reqal_good_t good,
   // Rail outputs
   output logic rail_enable,
   output logic rail_six_preset_1v2,
   output logic rail_six_preset_2v4
);
   import reqal_pkg::*;

   if (MS_CYCLES < 1) begin : g_bad_ms
      $error("reqal_top: MS_CYCLES must be at least 1");
   end

   logic [7:0] rail_goodness_mask_a;
   logic [7:0] rail_pin_select_and_mask_b;
   logic [7:0] delay_cfg;
   logic [7:0] next_mask_a;
   logic [7:0] next_mask_b;
   logic [7:0] next_delay;
   logic dp_write;
   logic [29:0] dp_idx;
   logic next_dp_write;
   logic [29:0] next_dp_idx;
   logic [31:0] next_hrdata;
   logic next_preset_1v2;
   logic next_preset_2v4;
   logic addr_take;
   logic [2:0] enable_source_select;
   logic mask_second_regulator_good;
   logic mask_second_bank_switch_good;
   logic rail_six_pin_voltage_option;
   logic source;
   logic [9:0] mask_all;
   logic goods_ok;
   logic qualified;
   logic delay_busy;

   assign enable_source_select = rail_pin_select_and_mask_b[PINSEL_LSB +: PINSEL_W];
   assign mask_second_regulator_good = rail_goodness_mask_a[7];
   assign mask_second_bank_switch_good = rail_pin_select_and_mask_b[MASKB_SECOND_BANK_BIT];
   assign rail_six_pin_voltage_option = rail_pin_select_and_mask_b[VOPT_BIT];

   // Zero wait state, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign addr_take = hsel && hready && htrans[1];

   // Register file next values
   always_comb begin
      next_mask_a = rail_goodness_mask_a;
      next_mask_b = rail_pin_select_and_mask_b;
      next_delay = delay_cfg;
      next_dp_write = addr_take && hwrite;
      next_dp_idx = addr_take ? haddr[31:2] : dp_idx;
      next_hrdata = hrdata;
      if (dp_write) begin
         if (dp_idx == 30'(IDX_MASK_A)) begin
            next_mask_a = hwdata[7:0];
         end else if (dp_idx == 30'(IDX_MASK_B)) begin
            next_mask_b = hwdata[7:0];
         end else if (dp_idx == 30'(IDX_DELAY)) begin
            next_delay = hwdata[7:0];
         end
      end
      // Read data from the post-write values so a read right after a write sees it
      if (addr_take && !hwrite) begin
         if (haddr[31:2] == 30'(IDX_MASK_A)) begin
            next_hrdata = {24'h0, next_mask_a};
         end else if (haddr[31:2] == 30'(IDX_MASK_B)) begin
            next_hrdata = {24'h0, next_mask_b};
         end else if (haddr[31:2] == 30'(IDX_DELAY)) begin
            next_hrdata = {24'h0, next_delay};
         end else if (haddr[31:2] == 30'(IDX_STATUS)) begin
            next_hrdata = {26'h0, rail_six_preset_2v4, rail_six_preset_1v2, delay_busy,
                           rail_enable, qualified, source};
         end else begin
            next_hrdata = 32'h0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rail_goodness_mask_a <= RST_MASK_A;
         rail_pin_select_and_mask_b <= RST_MASK_B;
         delay_cfg <= RST_DELAY;
         dp_write <= 1'b0;
         dp_idx <= 30'h0;
         hrdata <= 32'h0;
      end else begin
         rail_goodness_mask_a <= next_mask_a;
         rail_pin_select_and_mask_b <= next_mask_b;
         delay_cfg <= next_delay;
         dp_write <= next_dp_write;
         dp_idx <= next_dp_idx;
         hrdata <= next_hrdata;
      end
   end

   // Enable source multiplexer
   always_comb begin
      source = 1'b0;
      unique case (enable_source_select)
         SEL_IN_ONE: source = ctl.control_input_one;
         SEL_IN_TWO: source = ctl.control_input_two;
         SEL_IN_FIVE: source = ctl.control_input_five;
         SEL_IN_FOUR: source = ctl.control_input_four;
         SEL_IN_THREE: source = ctl.control_input_three;
         SEL_IN_PAIR: source = ctl.control_input_three & ctl.control_input_four;
         SEL_IN_SIX: source = ctl.control_input_six;
         SEL_ONE: source = 1'b1;
      endcase
   end

   // Masked good terms: a set mask bit forces its term true
   assign mask_all = {rail_pin_select_and_mask_b[MASKB_SHARED_BIT], mask_second_bank_switch_good,
                      mask_second_regulator_good, rail_goodness_mask_a[6:0]};
   assign goods_ok = &(good | mask_all);
   assign qualified = source & goods_ok;

   reqal_edge_delay #(
      .MS_CYCLES(MS_CYCLES)
   ) u_delay (
      .hclk(hclk),
      .hresetn(hresetn),
      .request(qualified),
      .rise_code(delay_cfg[RISE_LSB +: DLY_W]),
      .fall_code(delay_cfg[FALL_LSB +: DLY_W]),
      .level(rail_enable),
      .busy(delay_busy)
   );

   // Pin voltage override for step-down rail six
   always_comb begin
      next_preset_1v2 = 1'b0;
      next_preset_2v4 = 1'b0;
      if (rail_six_pin_voltage_option && second_control_pin && !sleep_pin) begin
         next_preset_1v2 = !rail_six_coarse_step;
         next_preset_2v4 = rail_six_coarse_step;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rail_six_preset_1v2 <= 1'b0;
         rail_six_preset_2v4 <= 1'b0;
      end else begin
         rail_six_preset_1v2 <= next_preset_1v2;
         rail_six_preset_2v4 <= next_preset_2v4;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_mask_required: assert property (
      (qualified && rail_goodness_mask_a[0] == 1'b0) |-> good.step_down_rail[0])
      else $error("Enable qualified with an unmasked rail not good");
   a_mask_a_write: assert property (
      (addr_take && hwrite && haddr[31:2] == 30'(IDX_MASK_A)) |=> ##1 rail_goodness_mask_a == $past(hwdata[7:0]))
      else $error("First mask byte did not take the written value");
   a_mask_b_bits: assert property (
      (!mask_second_bank_switch_good && !good.second_bank_first_switch) |-> !qualified)
      else $error("Second bank switch good not required");
   a_pin_pair: assert property (
      (enable_source_select == SEL_IN_PAIR && goods_ok) |-> qualified == (ctl.control_input_three && ctl.control_input_four))
      else $error("Pin pair select wrong");
   a_const_one: assert property (
      (enable_source_select == SEL_ONE && goods_ok) |-> qualified)
      else $error("Constant one source did not enable");
   a_option_off: assert property (
      !rail_six_pin_voltage_option |=> !rail_six_preset_1v2 && !rail_six_preset_2v4)
      else $error("Override active with option off");
   a_coarse_pick: assert property (
      (rail_six_pin_voltage_option && second_control_pin && !sleep_pin && rail_six_coarse_step)
      |=> rail_six_preset_2v4 && !rail_six_preset_1v2)
      else $error("Coarse step did not pick 2.4 V");
   a_sleep_wins: assert property (
      sleep_pin |=> !rail_six_preset_1v2 && !rail_six_preset_2v4)
      else $error("Sleep did not override pin voltage");
   a_rise_zero: assert property (
      (delay_cfg[RISE_LSB +: DLY_W] == 3'h0 && !delay_busy && !rail_enable && qualified) |=> rail_enable)
      else $error("Rise with no delay not passed in one cycle");
   a_reserved_inert: assert property (
      $changed(rail_pin_select_and_mask_b[6:5]) && $stable(rail_pin_select_and_mask_b[4:0])
      && $stable(rail_goodness_mask_a) && $stable(ctl) && $stable(good) |-> $stable(qualified))
      else $error("Reserved bits changed the enable");
endmodule : reqal_top

//--- bench/reqal_rails_model.sv
/*
 Model of the other rails: each good flag follows its rail's on request
 after SETTLE clock edges, as a rail output needs time to come up.
 Assumes requests are driven synchronously to hclk.
*/
`timescale 1ns/1ps
module reqal_rails_model #(
   parameter int SETTLE = 2
) (
   // Clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // Rail requests and good flags
   input wire reqal_pkg::reqal_good_t rail_on,
   output reqal_pkg::reqal_good_t good
);
   import reqal_pkg::*;
   reqal_good_t stage [SETTLE];
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < SETTLE; i++) stage[i] <= '0;
      end else begin
         stage[0] <= rail_on;
         for (int i = 1; i < SETTLE; i++) stage[i] <= stage[i - 1];
      end
   end
   assign good = stage[SETTLE - 1];
endmodule : reqal_rails_model

//--- bench/reqal_top_tb.sv
/*
 Self-checking bench for the rail enable qualifier: AHB-Lite read and write
 tasks, then source select, masking, edge delay and preset scenarios.
 Assumes a short MS_CYCLES so the delays stay brief.
*/
`timescale 1ns/1ps
module reqal_top_tb;
   import reqal_pkg::*;
   localparam int MS = 10;
   localparam logic [31:0] A_MA = {22'h0, IDX_MASK_A, 2'h0};
   localparam logic [31:0] A_MB = {22'h0, IDX_MASK_B, 2'h0};
   localparam logic [31:0] A_DL = {22'h0, IDX_DELAY, 2'h0};
   localparam logic [31:0] A_ST = {22'h0, IDX_STATUS, 2'h0};
   localparam logic [31:0] A_UN = 32'h0000_0100;
   // Pins that each source code needs high
   localparam logic [5:0] PIN [8] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0C, 6'h20, 6'h00};
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   reqal_ctl_t ctl;
   logic second_control_pin, sleep_pin, rail_six_coarse_step;
   reqal_good_t rail_on, good;
   logic rail_enable, p12, p24;
   int failures, total_checks;

   reqal_top #(.MS_CYCLES(MS)) dut (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .ctl(ctl),
      .second_control_pin(second_control_pin), .sleep_pin(sleep_pin),
      .rail_six_coarse_step(rail_six_coarse_step), .good(good), .rail_enable(rail_enable),
      .rail_six_preset_1v2(p12), .rail_six_preset_2v4(p24)
   );

   reqal_rails_model #(.SETTLE(2)) rails (
      .hclk(hclk), .hresetn(hresetn), .rail_on(rail_on), .good(good)
   );

   initial begin
      hclk = 1'b0;
      forever #2.5 hclk = ~hclk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic test_done;
      if (failures == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done

   // One single transfer: address phase, then data phase
   task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] wd);
      @(posedge hclk);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'b1;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic wr(input logic [31:0] a, input logic [7:0] d);
      bus(a, 1'b1, {24'h0, d});
   endtask : wr

   task automatic rdc(input string what, input logic [31:0] a, input logic [31:0] exp);
      bus(a, 1'b0, 32'h0);
      chk(what, exp, rd);
   endtask : rdc

   task automatic wait_n(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask : wait_n

   // Enable edge on control input one, checked either side of the delay
   task automatic edge_check(input logic v, input int n);
      @(posedge hclk);
      ctl <= {5'h00, v};
      @(posedge hclk);
      wait_n(n - 1);
      chk("before_edge", !v, rail_enable);
      wait_n(1);
      chk("after_edge", v, rail_enable);
   endtask : edge_check

   initial begin
      repeat (20000) @(posedge hclk);
      failures++;
      test_done();
   end

   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      ctl = '0;
      second_control_pin = 1'b0;
      sleep_pin = 1'b0;
      rail_six_coarse_step = 1'b0;
      rail_on = '0;
      failures = 0;
      total_checks = 0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
      rdc("mask_a", A_MA, 32'h0);
      rdc("mask_b", A_MB, 32'h0);
      rdc("delay", A_DL, 32'h0);
      chk("reset_enable", 1'b0, rail_enable);
      chk("hreadyout", 1'b1, hreadyout);
      wr(A_MA, 8'hA5);
      rdc("mask_a", A_MA, 32'hA5);
      wr(A_MB, 8'h6E);
      rdc("mask_b", A_MB, 32'h6E);
      wr(A_MB, 8'h0E);
      rdc("mask_b_reserved", A_MB, 32'h0E);
      wr(A_UN, 8'hFF);
      rdc("unmapped", A_UN, 32'h0);
      chk("hresp", 1'b0, hresp);
      // Every source code with its pins high, low and lowest pin cleared, partly high only for the pair
      wr(A_MA, 8'hFF);
      for (int c = 0; c < 8; c++) begin
         wr(A_MB, {3'h0, c[2:0], 2'h3});
         for (int k = 0; k < 3; k++) begin
            @(posedge hclk);
            ctl <= k == 0 ? PIN[c] : k == 1 ? ~PIN[c] : PIN[c] & (PIN[c] - 6'h01);
            wait_n(3);
            chk("source", k == 0 || c == 7, rail_enable);
         end
      end
      // One rail not good at a time, then its mask bit set
      wr(A_MA, 8'h00);
      wr(A_MB, 8'h1C);
      for (int i = 0; i < 10; i++) begin
         @(posedge hclk);
         rail_on <= ~(10'h001 << i);
         wait_n(5);
         chk("mask_clear", 1'b0, rail_enable);
         if (i < 8) wr(A_MA, 8'h01 << i);
         else wr(A_MB, 8'h1C | (8'h01 << (i - 8)));
         wait_n(3);
         chk("mask_set", 1'b1, rail_enable);
         wr(A_MA, 8'h00);
         wr(A_MB, 8'h1C);
      end
      // Rise 2 ms, fall 4 ms, with a cancelled fall between
      wr(A_MA, 8'hFF);
      wr(A_MB, 8'h03);
      wr(A_DL, 8'h11);
      @(posedge hclk);
      ctl <= '0;
      wait_n(3);
      edge_check(1'b1, 2 * MS);
      rdc("status_on", A_ST, 32'h0000_0007);
      @(posedge hclk);
      ctl <= '0;
      wait_n(10);
      rdc("status_busy", A_ST, 32'h0000_000C);
      @(posedge hclk);
      ctl <= 6'h01;
      wait_n(40);
      chk("fall_cancel", 1'b1, rail_enable);
      edge_check(1'b0, 4 * MS);
      // Preset table over option, pin, sleep and step size
      for (int i = 0; i < 16; i++) begin
         if (i % 8 == 0) wr(A_MB, {i[3], 7'h03});
         @(posedge hclk);
         second_control_pin <= i[0];
         sleep_pin <= i[1];
         rail_six_coarse_step <= i[2];
         wait_n(2);
         chk("preset_1v2", i[3] & i[0] & !i[1] & !i[2], p12);
         chk("preset_2v4", i[3] & i[0] & !i[1] & i[2], p24);
      end
      test_done();
   end
endmodule : reqal_top_tb
